//--- frv_consts.vh
// constants for the frame receive validity and crc block
`ifndef FRV_CONSTS_VH
`define FRV_CONSTS_VH
`define FRV_W_DATA      32
`define FRV_FIFO_DEPTH  8
`define FRV_FIFO_AW     3
`define FRV_CRC_POLY    32'h04C11DB7
`define FRV_CRC_INIT    32'hFFFFFFFF
`define FRV_CRC_RESID   32'hC704DD7B
// decoded ordered set kinds from the word decoder
`define FRV_OS_W        4
`define FRV_OS_NONE     4'h0
`define FRV_OS_SOF      4'h1
`define FRV_OS_EOFN     4'h2
`define FRV_OS_EOFT     4'h3
`define FRV_OS_EOFNI    4'h4
`define FRV_OS_EOFA     4'h5
`define FRV_OS_OTHER    4'h6
// sof class field
`define FRV_CLS_W       2
`define FRV_CLS_2       2'h2
`define FRV_CLS_3       2'h3
`define FRV_CLS_F       2'h1
// verdict codes
`define FRV_VD_W        3
`define FRV_VD_ACCEPT   3'h0
`define FRV_VD_REJECT   3'h1
`define FRV_VD_DISCARD  3'h2
`define FRV_VD_INVALID  3'h3
`define FRV_VD_ABORT    3'h4
`define FRV_RJT_LEN     8'h13
`define FRV_MAX_WORDS   12'h213
`define FRV_CNT_W       16
`define FRV_CNT_ONE     16'h0001
`define FRV_CNT_MAX     16'hFFFF
`endif

//--- frv_fifo.v
// parameterised valid/ready fifo for received frame words
module frv_fifo #(
    parameter WIDTH = 34,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             reset_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_r;
    reg [AW:0]      rd_r;
    wire            full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    wire            empty = (wr_r == rd_r);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rd_r[AW-1:0]];
    always @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            mem[wr_r[AW-1:0]] <= in_data_i;
        end
    end
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end else begin
            if (in_valid_i && !full) begin
                wr_r <= wr_r + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule

//--- frv_rx.v
// receive frame delimiting, validity, crc check and verdict logic
// Function
// - an aborted partial frame is discarded with no reply
// - an abort delimiter is never turned into an invalid delimiter when forwarded
// - forwarding supplies abort on link failure or, in fabric mode, for an overlong frame
// - an invalid-ended frame gets no response; its data may be used
// - data words outside an open start/end pair are dropped
// - capture starts only on a start-of-frame ordered set
// - a code violation during capture marks an invalid word in that frame
// - capture runs until any ordered set or link failure, even when oversize
// - oversize data may be dropped; acknowledged classes reject with code 13h
// - an abort-ended frame is discarded entirely under either policy
// - valid only with normal/terminate end, whole words, no invalid word
// - no port reject is ever sent for an invalid frame
// - a rejectable or busy valid class 3 frame is silently dropped
// - each invalid word and crc error bumps its event counter; here only data words during capture and crc errors of non-abort frames count
// - a valid frame with a disallowed delimiter pair is rejectable
// - invalid frame data is used only under process policy, else discarded
// - data field is word aligned and a multiple of four bytes
// - a word-aligned crc covers headers and data, not delimiters
// - crc is checked after decoding and descrambling
// - bytes enter the crc bit-reversed, crc bytes come out bit-reversed
// - a crc failure is handled like a delimiter validity failure
`include "frv_consts.vh"
module frv_rx (
    input  wire                  clk_i,
    input  wire                  reset_i,
    input  wire [31:0]           word_i,
    input  wire                  word_valid_i,
    input  wire [`FRV_OS_W-1:0]  os_kind_i,
    input  wire [`FRV_CLS_W-1:0] sof_class_i,
    input  wire                  sof_init_i,
    input  wire                  code_viol_i,
    input  wire [1:0]            partial_bytes_i,
    input  wire                  link_fail_i,
    input  wire                  busy_i,
    input  wire                  process_policy_i,
    input  wire                  oversize_drop_i,
    input  wire                  fabric_mode_i,
    output wire [31:0]           rx_data_o,
    output wire                  rx_last_o,
    output wire                  rx_first_o,
    output wire                  rx_valid_o,
    input  wire                  rx_ready_i,
    output wire                  overflow_o,
    output reg                   verdict_valid_o,
    output reg  [`FRV_VD_W-1:0]  verdict_o,
    output reg  [7:0]            reject_reason_o,
    output reg                   send_reject_o,
    output reg                   use_data_o,
    output reg  [`FRV_OS_W-1:0]  fwd_eof_o,
    output reg  [`FRV_CNT_W-1:0] itw_count_o,
    output reg  [`FRV_CNT_W-1:0] crc_err_count_o,
    output wire                  in_frame_o
);
    localparam ST_IDLE = 1'b0;
    localparam ST_CAPT = 1'b1;

    // one crc step over a 32-bit word, bytes fed bit-reversed in byte order
    function [31:0] crc_word;
        input [31:0] c;
        input [31:0] w;
        integer i;
        integer b;
        reg [31:0] r;
        reg        fb;
        begin
            r = c;
            for (b = 0; b < 4; b = b + 1) begin
                for (i = 0; i < 8; i = i + 1) begin
                    fb = r[31] ^ w[31 - 8*b - 7 + i];
                    r  = {r[30:0], 1'b0} ^ (fb ? `FRV_CRC_POLY : 32'h00000000);
                end
            end
            crc_word = r;
        end
    endfunction

    // delimiter pairs allowed per class
    function pair_ok;
        input [`FRV_CLS_W-1:0] cls;
        input [`FRV_OS_W-1:0]  eof;
        begin
            pair_ok = (cls == `FRV_CLS_2 || cls == `FRV_CLS_3) &&
                      (eof == `FRV_OS_EOFN || eof == `FRV_OS_EOFT);
        end
    endfunction

    // three-stage sync on the link failure pin
    reg [2:0] lf_sync_r;
    reg       lf_r;
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lf_sync_r <= 3'h0;
            lf_r      <= 1'b0;
        end else begin
            lf_sync_r <= {lf_sync_r[1:0], link_fail_i};
            if (lf_sync_r[1] == lf_sync_r[2]) begin
                lf_r <= lf_sync_r[2];
            end
        end
    end

    reg                  state_r;
    reg [`FRV_CLS_W-1:0] cls_r;
    reg [31:0]           crc_r;
    reg                  itw_r;
    reg                  misalign_r;
    reg [11:0]           words_r;
    reg                  oversize_r;
    reg                  first_r;
    reg                  have_r;
    reg [31:0]           hold_r;

    wire is_os     = word_valid_i && (os_kind_i != `FRV_OS_NONE);
    wire is_data   = word_valid_i && (os_kind_i == `FRV_OS_NONE);
    wire in_frame  = (state_r == ST_CAPT);
    wire frame_end = in_frame && (is_os || lf_r);
    assign in_frame_o = in_frame;

    // data goes through the fifo one word late so the crc word never leaves
    wire        fifo_in_ready;
    wire        drop_big   = oversize_r && oversize_drop_i;
    wire        push       = in_frame && is_data && have_r && !drop_big;
    assign overflow_o = in_frame && is_data && have_r && !drop_big && !fifo_in_ready;

    frv_fifo #(
        .WIDTH (34),
        .DEPTH (`FRV_FIFO_DEPTH),
        .AW    (`FRV_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_data_i   ({first_r, 1'b0, hold_r}),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  ({rx_first_o, rx_last_o, rx_data_o}),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i)
    );

    // verdict combinational terms at frame end
    reg [`FRV_OS_W-1:0] eof_k;
    reg                 valid_fr;
    reg                 crc_bad;
    reg                 rejectable;
    always @* begin
        eof_k      = lf_r ? `FRV_OS_EOFA : os_kind_i;
        crc_bad    = (crc_r != `FRV_CRC_RESID);
        valid_fr   = (eof_k == `FRV_OS_EOFN || eof_k == `FRV_OS_EOFT) &&
                     !misalign_r && !itw_r && !crc_bad;
        rejectable = !pair_ok(cls_r, eof_k) || busy_i || oversize_r;
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r         <= ST_IDLE;
            cls_r           <= `FRV_CLS_3;
            crc_r           <= `FRV_CRC_INIT;
            itw_r           <= 1'b0;
            misalign_r      <= 1'b0;
            words_r         <= 12'h000;
            oversize_r      <= 1'b0;
            first_r         <= 1'b0;
            have_r          <= 1'b0;
            hold_r          <= 32'h00000000;
            verdict_valid_o <= 1'b0;
            verdict_o       <= `FRV_VD_ACCEPT;
            reject_reason_o <= 8'h00;
            send_reject_o   <= 1'b0;
            use_data_o      <= 1'b0;
            fwd_eof_o       <= `FRV_OS_NONE;
            itw_count_o     <= 16'h0000;
            crc_err_count_o <= 16'h0000;
        end else begin
            verdict_valid_o <= 1'b0;
            send_reject_o   <= 1'b0;
            use_data_o      <= 1'b0;
            if (push) begin
                first_r <= 1'b0;
            end
            if (!in_frame) begin
                // stray data outside a delimiter pair is dropped here
                if (word_valid_i && os_kind_i == `FRV_OS_SOF && !lf_r) begin
                    state_r    <= ST_CAPT;
                    cls_r      <= sof_class_i;
                    crc_r      <= `FRV_CRC_INIT;
                    itw_r      <= 1'b0;
                    misalign_r <= 1'b0;
                    words_r    <= 12'h000;
                    oversize_r <= 1'b0;
                    first_r    <= 1'b1;
                    have_r     <= 1'b0;
                end
            end else if (frame_end) begin
                state_r         <= ST_IDLE;
                have_r          <= 1'b0;
                verdict_valid_o <= 1'b1;
                // abort passes through unchanged; invalid frames forward as invalid except overlong ones in fabric mode, cut with abort
                if (eof_k == `FRV_OS_EOFA) begin
                    fwd_eof_o <= `FRV_OS_EOFA;
                end else if (fabric_mode_i && oversize_r) begin
                    // a fabric element cuts an overlong frame with abort
                    fwd_eof_o <= `FRV_OS_EOFA;
                end else if (!valid_fr || eof_k == `FRV_OS_EOFNI) begin
                    fwd_eof_o <= `FRV_OS_EOFNI;
                end else begin
                    fwd_eof_o <= eof_k;
                end
                if (crc_bad && eof_k != `FRV_OS_EOFA && crc_err_count_o != `FRV_CNT_MAX) begin
                    crc_err_count_o <= crc_err_count_o + `FRV_CNT_ONE;
                end
                if (eof_k == `FRV_OS_EOFA) begin
                    verdict_o <= `FRV_VD_ABORT;
                end else if (!valid_fr) begin
                    verdict_o  <= `FRV_VD_INVALID;
                    use_data_o <= process_policy_i;
                end else if (rejectable && cls_r == `FRV_CLS_3) begin
                    verdict_o <= `FRV_VD_DISCARD;
                end else if (cls_r == `FRV_CLS_F) begin
                    verdict_o <= `FRV_VD_DISCARD;
                end else if (rejectable && !busy_i) begin
                    verdict_o       <= `FRV_VD_REJECT;
                    send_reject_o   <= !fabric_mode_i;
                    reject_reason_o <= oversize_r ? `FRV_RJT_LEN : 8'h00;
                end else if (busy_i) begin
                    verdict_o <= `FRV_VD_DISCARD;
                end else begin
                    verdict_o  <= `FRV_VD_ACCEPT;
                    use_data_o <= 1'b1;
                end
            end else if (is_data) begin
                // crc checked on descrambled words from the decoder
                crc_r <= crc_word(crc_r, word_i);
                if (code_viol_i) begin
                    itw_r <= 1'b1;
                    if (itw_count_o != `FRV_CNT_MAX) begin
                        itw_count_o <= itw_count_o + `FRV_CNT_ONE;
                    end
                end
                if (partial_bytes_i != 2'h0) begin
                    misalign_r <= 1'b1;
                end
                if (words_r == `FRV_MAX_WORDS) begin
                    oversize_r <= 1'b1;
                end else begin
                    words_r <= words_r + 12'h001;
                end
                hold_r <= word_i;
                have_r <= 1'b1;
            end
        end
    end
endmodule

//--- frv_rx_properties.sv
// concurrent checks on the receive block's ports
`include "frv_consts.vh"
module frv_rx_properties (
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire logic                  word_valid_i,
    input wire logic [`FRV_OS_W-1:0]  os_kind_i,
    input wire logic                  in_frame_o,
    input wire logic                  verdict_valid_o,
    input wire logic [`FRV_VD_W-1:0]  verdict_o,
    input wire logic                  send_reject_o,
    input wire logic                  use_data_o,
    input wire logic [`FRV_OS_W-1:0]  fwd_eof_o,
    input wire logic [`FRV_CNT_W-1:0] itw_count_o,
    input wire logic [`FRV_CNT_W-1:0] crc_err_count_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_end;
        in_frame_o && word_valid_i && os_kind_i inside {[`FRV_OS_EOFN:`FRV_OS_EOFA]};
    endsequence
    sequence s_abort_end;
        s_end ##0 os_kind_i == `FRV_OS_EOFA;
    endsequence
    a_sof_opens: assert property (!in_frame_o && word_valid_i &&
        os_kind_i == `FRV_OS_SOF |=> in_frame_o)
        else $error("capture did not start on a start delimiter");
    a_end_closes: assert property (s_end |=> !in_frame_o && verdict_valid_o)
        else $error("end delimiter did not close capture with a verdict");
    a_verdict_pulse: assert property (verdict_valid_o |=> !verdict_valid_o)
        else $error("verdict strobe longer than one cycle");
    a_abort_kept: assert property (s_abort_end |=>
        verdict_o == `FRV_VD_ABORT && fwd_eof_o != `FRV_OS_EOFNI)
        else $error("abort frame not kept as abort");
    a_abort_discards: assert property (verdict_valid_o &&
        verdict_o == `FRV_VD_ABORT |-> !use_data_o && !send_reject_o)
        else $error("aborted frame used or answered");
    a_invalid_silent: assert property (verdict_valid_o &&
        verdict_o != `FRV_VD_REJECT |-> !send_reject_o)
        else $error("reject sent for a frame that is not rejectable");
    a_itw_step: assert property ($changed(itw_count_o) |->
        itw_count_o == $past(itw_count_o) + 16'h0001)
        else $error("invalid word count moved by other than one");
    a_crc_step: assert property ($changed(crc_err_count_o) |->
        crc_err_count_o == $past(crc_err_count_o) + 16'h0001)
        else $error("crc error count moved by other than one");
endmodule
bind frv_rx frv_rx_properties chk (.clk_i, .reset_i, .word_valid_i, .os_kind_i, .in_frame_o,
    .verdict_valid_o, .verdict_o, .send_reject_o, .use_data_o, .fwd_eof_o, .itw_count_o,
    .crc_err_count_o);

//--- frv_far_port.sv
// far port model: sends framed words with a generated crc
`include "frv_consts.vh"
module frv_far_port (
    input  wire logic        clk_i,
    output logic [31:0]      word_o,
    output logic             valid_o,
    output logic [3:0]       os_o,
    output logic [1:0]       cls_o,
    output logic             viol_o,
    output logic [1:0]       part_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word_o = 32'h0;
        valid_o = 1'b0;
        os_o = `FRV_OS_NONE;
        cls_o = `FRV_CLS_3;
        viol_o = 1'b0;
        part_o = 2'h0;
    end
    // bytes enter msb-first bit-reversed, preset ones
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
        for (int i = 0; i < 32; i++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ w[24 - 8 * (i / 8) + i % 8]) ? `FRV_CRC_POLY : 32'h0);
        return c;
    endfunction
    task automatic put(input logic [3:0] k, input logic [31:0] w, input logic v, input logic [1:0] p);
        @(posedge clk_i);
        os_o <= k;
        word_o <= w;
        viol_o <= v;
        part_o <= p;
        valid_o <= 1'b1;
    endtask
    // whole words except where pt marks partial bytes on the crc word, crc word-aligned after data, delimiters outside crc
    // eof kind chosen by the bench: normal, terminate, normal-invalid or abort on a word boundary
    task automatic send_frame(input logic [1:0] cls, input int n, input logic [3:0] eof,
                              input logic bad, input int va, input logic [1:0] pt);
        logic [31:0] c;
        logic [31:0] d;
        logic [31:0] f;
        c = `FRV_CRC_INIT;
        @(posedge clk_i);
        cls_o <= cls;
        put(`FRV_OS_SOF, 32'h0, 1'b0, 2'h0);
        for (int i = 0; i < n; i++) begin
            d = 32'hA5000000 | 32'(i);
            c = crc_step(c, d);
            put(`FRV_OS_NONE, d, i == va, 2'h0);
        end
        // remainder complemented, each byte bit-reversed
        for (int i = 0; i < 32; i++)
            f[i] = ~c[(i & 24) + 7 - (i & 7)];
        put(`FRV_OS_NONE, f ^ {31'h0, bad}, 1'b0, pt);
        put(eof, 32'h0, 1'b0, 2'h0);
        @(posedge clk_i);
        valid_o <= 1'b0;
        os_o <= `FRV_OS_NONE;
        word_o <= ~word_o;
    endtask
endmodule

//--- testbench.sv
// self-checking bench for the frame receive block
`include "frv_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] word;
    logic valid;
    logic [3:0] os;
    logic [1:0] cls;
    logic viol;
    logic [1:0] part;
    logic proc = 1'b0;
    logic odrop = 1'b0;
    logic busy = 1'b0;
    logic fabric = 1'b0;
    logic lfail = 1'b0;
    logic rx_ready = 1'b1;
    wire [31:0] rx_data_o;
    wire rx_first_o, rx_valid_o, overflow_o, verdict_valid_o, send_reject_o, use_data_o;
    wire [2:0] verdict_o;
    wire [7:0] reject_reason_o;
    wire [3:0] fwd_eof_o;
    wire [15:0] itw_count_o, crc_err_count_o;
    int n_fail = 0;
    int compares = 0;
    int n_pop = 0;
    logic [31:0] first_w;
    logic ovf = 1'b0;
    logic [2:0] vd;
    logic rej, use_d;
    frv_far_port far (.clk_i(clk_i), .word_o(word), .valid_o(valid), .os_o(os), .cls_o(cls),
        .viol_o(viol), .part_o(part));
    frv_rx dut (.clk_i(clk_i), .reset_i(reset_i), .word_i(word), .word_valid_i(valid),
        .os_kind_i(os), .sof_class_i(cls), .sof_init_i(1'b0), .code_viol_i(viol),
        .partial_bytes_i(part), .link_fail_i(lfail), .busy_i(busy), .process_policy_i(proc),
        .oversize_drop_i(odrop), .fabric_mode_i(fabric), .rx_data_o(rx_data_o), .rx_last_o(),
        .rx_first_o(rx_first_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready),
        .overflow_o(overflow_o), .verdict_valid_o(verdict_valid_o), .verdict_o(verdict_o),
        .reject_reason_o(reject_reason_o), .send_reject_o(send_reject_o),
        .use_data_o(use_data_o), .fwd_eof_o(fwd_eof_o), .itw_count_o(itw_count_o),
        .crc_err_count_o(crc_err_count_o), .in_frame_o());
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (rx_valid_o && rx_ready) begin
            n_pop <= n_pop + 1;
            if (rx_first_o)
                first_w <= rx_data_o;
        end
        if (overflow_o)
            ovf <= 1'b1;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_verdict();
        int k;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (verdict_valid_o !== 1'b1 && k < 20);
        if (verdict_valid_o !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: no verdict", $time);
            give_verdict();
        end else begin
            vd = verdict_o;
            rej = send_reject_o;
            use_d = use_data_o;
        end
    endtask
    task automatic frame(input logic [1:0] c, input int n, input logic [3:0] eof,
                         input logic bad, input int va, input logic [1:0] pt);
        far.send_frame(c, n, eof, bad, va, pt);
        wait_verdict();
    endtask
    task automatic t_good();
        logic [3:0] eofs[2] = '{`FRV_OS_EOFN, `FRV_OS_EOFT};
        for (int i = 0; i < 4; i++)
            far.put(`FRV_OS_NONE, 32'h5A5A0000, 1'b0, 2'h0);
        for (int i = 0; i < 2; i++) begin
            frame(`FRV_CLS_3, 6, eofs[i], 1'b0, -1, 2'h0);
            check(vd, `FRV_VD_ACCEPT);
            repeat (4) @(posedge clk_i);
            check(first_w, 32'hA5000000);
            check(n_pop, 6 * (i + 1));
        end
        check(crc_err_count_o, 16'h0);
    endtask
    task automatic t_faults();
        logic [15:0] e0;
        logic [15:0] i0;
        e0 = crc_err_count_o;
        frame(`FRV_CLS_2, 5, `FRV_OS_EOFT, 1'b1, -1, 2'h0);
        check(vd, `FRV_VD_INVALID);
        check(rej, 1'b0);
        check(crc_err_count_o, e0 + 16'h0001);
        i0 = itw_count_o;
        @(posedge clk_i);
        proc <= 1'b1;
        frame(`FRV_CLS_2, 5, `FRV_OS_EOFN, 1'b0, 2, 2'h0);
        check(vd, `FRV_VD_INVALID);
        check(use_d, 1'b1);
        check(itw_count_o, i0 + 16'h0001);
        frame(`FRV_CLS_2, 5, `FRV_OS_EOFN, 1'b0, -1, 2'h2);
        check(vd, `FRV_VD_INVALID);
        frame(`FRV_CLS_2, 5, `FRV_OS_EOFA, 1'b0, -1, 2'h0);
        check(vd, `FRV_VD_ABORT);
        check({rej, use_d}, 2'b00);
        check(fwd_eof_o == `FRV_OS_EOFNI, 1'b0);
        frame(`FRV_CLS_2, 5, `FRV_OS_EOFN, 1'b0, -1, 2'h0);
        check(vd, `FRV_VD_ACCEPT);
        frame(`FRV_CLS_2, 5, `FRV_OS_EOFNI, 1'b0, -1, 2'h0);
        check(rej, 1'b0);
        check(vd, `FRV_VD_INVALID);
        @(posedge clk_i);
        proc <= 1'b0;
    endtask
    task automatic t_control();
        int p0;
        @(posedge clk_i);
        busy <= 1'b1;
        frame(`FRV_CLS_3, 3, `FRV_OS_EOFN, 1'b0, -1, 2'h0);
        check({vd, rej}, {`FRV_VD_DISCARD, 1'b0});
        frame(`FRV_CLS_2, 3, `FRV_OS_EOFT, 1'b0, -1, 2'h0);
        check({vd, rej}, {`FRV_VD_DISCARD, 1'b0});
        @(posedge clk_i);
        busy <= 1'b0;
        frame(2'h0, 3, `FRV_OS_EOFN, 1'b0, -1, 2'h0);
        check({vd, rej}, {`FRV_VD_REJECT, 1'b1});
        check(reject_reason_o, 8'h00);
        @(posedge clk_i);
        fabric <= 1'b1;
        odrop <= 1'b1;
        p0 = n_pop;
        frame(`FRV_CLS_3, 12'h214, `FRV_OS_EOFN, 1'b0, -1, 2'h0);
        check(vd, `FRV_VD_DISCARD);
        check(fwd_eof_o, `FRV_OS_EOFA);
        repeat (4) @(posedge clk_i);
        check(n_pop - p0, 32'h213);
        @(posedge clk_i);
        fabric <= 1'b0;
        odrop <= 1'b0;
    endtask
    task automatic t_linkfail();
        far.put(`FRV_OS_SOF, 32'h00000000, 1'b0, 2'h0);
        far.put(`FRV_OS_NONE, 32'h12345678, 1'b0, 2'h0);
        @(posedge clk_i);
        lfail <= 1'b1;
        wait_verdict();
        check(vd, `FRV_VD_ABORT);
        check(fwd_eof_o, `FRV_OS_EOFA);
        check({rej, use_d}, 2'b00);
        @(posedge clk_i);
        lfail <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic t_oversize();
        frame(`FRV_CLS_2, 12'h213, `FRV_OS_EOFN, 1'b0, -1, 2'h0);
        check({vd, rej}, {`FRV_VD_REJECT, 1'b1});
        check(reject_reason_o, `FRV_RJT_LEN);
        frame(`FRV_CLS_3, 12'h213, `FRV_OS_EOFN, 1'b0, -1, 2'h0);
        check({vd, rej}, {`FRV_VD_DISCARD, 1'b0});
    endtask
    task automatic t_fifo();
        @(posedge clk_i);
        rx_ready <= 1'b0;
        frame(`FRV_CLS_3, 12, `FRV_OS_EOFN, 1'b0, -1, 2'h0);
        check(ovf, 1'b1);
        @(posedge clk_i);
        rx_ready <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(rx_valid_o, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        t_good();
        t_faults();
        t_oversize();
        t_control();
        t_linkfail();
        t_fifo();
        give_verdict();
    end
endmodule
